// ### core/serial_io_cmd.sv
// command interpreter of a 16-line digital i/o module on a shared serial line
`timescale 1ns/1ns
`include "serial_io_regs.svh"

module serial_io_cmd
   import serial_io_pkg::*;
#(
   parameter int BIT_CYCLES = `BIT_CYCLES_DEF
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic rxdPin,
   output logic txdPin,
   output logic txDriveEn,
   input wire logic [15:0] lineIn,
   output logic [15:0] lineOut,
   output logic [15:0] lineOe
);
   logic [1:0] rxSync_q;
   logic [15:0] inMeta_q;
   logic [15:0] inSync_q;
   logic [7:0] rxByte;
   logic rxValid;
   parse_state_t state_q;
   op_t op_q;
   op_t opDec;
   logic [7:0] op1_q;
   logic match_q;
   logic [7:0] argHi_q;
   logic [7:0] addr_q;
   logic [7:0] tdly_q;
   logic [15:0] dir_q;
   logic [15:0] startup_q;
   logic [15:0] outState_q;
   logic [15:0] lineState;
   logic [11:0] waitBits_q;
   logic [15:0] txCnt_q;
   logic [3:0] txBits_q;
   logic [9:0] txShift_q;
   logic [2:0] respIdx_q;
   logic [2:0] respSel;
   logic [2:0] respLen;
   logic [7:0] respByte;
   logic loadByte;
   logic applyArg;

   // pins from outside pass two flops first
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rxSync_q <= 2'b11;
         inMeta_q <= 16'h0000;
         inSync_q <= 16'h0000;
      end else begin
         rxSync_q <= {rxSync_q[0], rxdPin};
         inMeta_q <= lineIn;
         inSync_q <= inMeta_q;
      end
   end

   serial_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
      .core_clk(core_clk),
      .rstn(rstn),
      .rxLine(rxSync_q[1]),
      .rxByte(rxByte),
      .rxValid(rxValid)
   );

   always_comb begin
      opDec = OP_NONE;
      if (op1_q == `CH_R && rxByte == `CH_D) begin
         opDec = OP_RD;
      end else if (op1_q == `CH_R && rxByte == `CH_C) begin
         opDec = OP_RC;
      end else if (op1_q == `CH_S && rxByte == `CH_O) begin
         opDec = OP_SO;
      end else if (op1_q == `CH_S && rxByte == `CH_D) begin
         opDec = OP_SD;
      end else if (op1_q == `CH_S && rxByte == `CH_S) begin
         opDec = OP_SS;
      end else if (op1_q == `CH_S && rxByte == `CH_A) begin
         opDec = OP_SA;
      end else if (op1_q == `CH_S && rxByte == `CH_C) begin
         opDec = OP_SC;
      end
   end

   // outputs read back what they drive, inputs what they sense
   assign lineState = (dir_q & outState_q) | (~dir_q & inSync_q);

   // the byte after the one in flight is picked ahead of its load
   always_comb begin
      respSel = respIdx_q;
      if (state_q == ST_SEND) begin
         respSel = respIdx_q + 3'h1;
      end
   end

   always_comb begin
      respLen = (op_q == OP_RD) ? `RD_LEN : `RC_LEN;
      case (respSel)
         3'h0: respByte = (op_q == OP_RD) ? lineState[15:8] : dir_q[15:8];
         3'h1: respByte = (op_q == OP_RD) ? lineState[7:0] : dir_q[7:0];
         3'h2: respByte = startup_q[15:8];
         3'h3: respByte = startup_q[7:0];
         3'h4: respByte = addr_q;
         default: respByte = tdly_q;
      endcase
   end

   assign applyArg = rxValid && state_q == ST_ARG2 && match_q;
   assign loadByte = (state_q == ST_WAIT && waitBits_q == 12'h000 && txCnt_q == 16'h0000)
      || (state_q == ST_SEND && txBits_q == 4'h0 && txCnt_q == 16'h0000
      && respIdx_q + 3'h1 < respLen);

   // command parsing, turn-around wait and answer transmission
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         op_q <= OP_NONE;
         op1_q <= 8'h00;
         match_q <= 1'b0;
         argHi_q <= 8'h00;
         waitBits_q <= 12'h000;
         txCnt_q <= 16'h0000;
         txBits_q <= 4'h0;
         txShift_q <= 10'h3FF;
         respIdx_q <= 3'h0;
         txdPin <= 1'b1;
         txDriveEn <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (rxValid && rxByte == `CH_START) begin
                  state_q <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (rxValid) begin
                  match_q <= (rxByte == addr_q);
                  state_q <= ST_OP1;
               end
            end
            ST_OP1: begin
               if (rxValid) begin
                  op1_q <= rxByte;
                  state_q <= ST_OP2;
               end
            end
            ST_OP2: begin
               if (rxValid) begin
                  op_q <= opDec;
                  case (opDec)
                     OP_RD, OP_RC: begin
                        // other modules stay silent
                        state_q <= match_q ? ST_WAIT : ST_IDLE;
                        waitBits_q <= 12'(tdly_q) * `BITS_PER_CHAR;
                        txCnt_q <= 16'(BIT_CYCLES - 1);
                        respIdx_q <= 3'h0;
                     end
                     OP_SO, OP_SD, OP_SS: state_q <= ST_ARG1;
                     OP_SA, OP_SC: state_q <= ST_ARG2;
                     default: state_q <= ST_IDLE;
                  endcase
               end
            end
            ST_ARG1: begin
               if (rxValid) begin
                  argHi_q <= rxByte;
                  state_q <= ST_ARG2;
               end
            end
            ST_ARG2: begin
               if (rxValid) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               if (txCnt_q != 16'h0000) begin
                  txCnt_q <= txCnt_q - 16'h0001;
               end else if (waitBits_q != 12'h000) begin
                  // each count is one bit period, ten counts per delay unit
                  waitBits_q <= waitBits_q - 12'h001;
                  txCnt_q <= 16'(BIT_CYCLES - 1);
               end else begin
                  state_q <= ST_SEND;
                  txDriveEn <= 1'b1;
                  txShift_q <= {1'b1, respByte, 1'b0};
                  txBits_q <= 4'hA;
               end
            end
            ST_SEND: begin
               if (txCnt_q != 16'h0000) begin
                  txCnt_q <= txCnt_q - 16'h0001;
               end else if (txBits_q != 4'h0) begin
                  txdPin <= txShift_q[0];
                  txShift_q <= {1'b1, txShift_q[9:1]};
                  txBits_q <= txBits_q - 4'h1;
                  txCnt_q <= 16'(BIT_CYCLES - 1);
               end else if (respIdx_q + 3'h1 < respLen) begin
                  respIdx_q <= respIdx_q + 3'h1;
                  txShift_q <= {1'b1, respByte, 1'b0};
                  txBits_q <= 4'hA;
               end else begin
                  // stop bit has run its full period before release
                  state_q <= ST_IDLE;
                  txDriveEn <= 1'b0;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // configuration and output state; kept in flops, reset stands in for power-up
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         addr_q <= `ADDR_RESET;
         tdly_q <= `TDLY_RESET;
         dir_q <= `DIR_RESET;
         startup_q <= `STARTUP_RESET;
         outState_q <= `STARTUP_RESET;
      end else if (applyArg) begin
         case (op_q)
            OP_SO: outState_q <= (outState_q & ~dir_q) | ({argHi_q, rxByte} & dir_q);
            OP_SD: dir_q <= {argHi_q, rxByte};
            OP_SS: startup_q <= (startup_q & ~dir_q) | ({argHi_q, rxByte} & dir_q);
            OP_SA: addr_q <= rxByte;
            OP_SC: tdly_q <= rxByte;
            default: addr_q <= addr_q;
         endcase
      end
   end

   assign lineOut = outState_q;
   assign lineOe = dir_q;

   a_so_masked: assert property (@(posedge core_clk) disable iff (!rstn)
      $stable(dir_q) |-> ((outState_q ^ $past(outState_q)) & ~dir_q) == 16'h0000)
      else $error("input line changed by a write");
   a_so_drive: assert property (@(posedge core_clk) disable iff (!rstn)
      (applyArg && op_q == OP_SO) |=> ((lineOut ^ $past({argHi_q, rxByte})) & lineOe) == 16'h0000)
      else $error("output line does not follow written bit");
   a_answer_match: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(txDriveEn) |-> match_q && (op_q == OP_RD || op_q == OP_RC))
      else $error("answer without matching address");
   a_delay_done: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(txDriveEn) |-> $past(waitBits_q) == 12'h000 && $past(state_q) == ST_WAIT)
      else $error("answer started before turn-around delay");
   a_rd_length: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_q == ST_SEND && op_q == OP_RD) |-> respIdx_q < `RD_LEN)
      else $error("read-lines answer longer than two bytes");
   a_rd_high_first: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_q == ST_WAIT && loadByte && op_q == OP_RD)
      |=> txShift_q[8:1] == $past(lineState[15:8]))
      else $error("read-lines first byte is not lines 15..8");
   a_rc_addr: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_q == ST_SEND && op_q == OP_RC && respIdx_q == `RC_ADDR_IDX - 3'h1 && loadByte)
      |=> txShift_q[8:1] == addr_q)
      else $error("fifth configuration byte is not the address");
   a_input_report: assert property (@(posedge core_clk) disable iff (!rstn)
      ((lineState ^ $past(lineIn, 2)) & ~dir_q) == 16'h0000)
      else $error("input line misreported");
   a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
      !txDriveEn |-> txdPin)
      else $error("line data active while not driving");
   a_rd_low_second: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_q == ST_SEND && op_q == OP_RD && respIdx_q == 3'h0 && loadByte)
      |=> txShift_q[8:1] == $past(lineState[7:0]))
      else $error("read-lines second byte is not lines 7..0");
   a_rc_delay: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_q == ST_SEND && op_q == OP_RC && respIdx_q == `RC_TDLY_IDX - 3'h1 && loadByte)
      |=> txShift_q[8:1] == tdly_q)
      else $error("sixth configuration byte is not the delay");
   a_sd_define: assert property (@(posedge core_clk) disable iff (!rstn)
      (applyArg && op_q == OP_SD) |=> lineOe == $past({argHi_q, rxByte}))
      else $error("direction write not applied");
   a_drive_window: assert property (@(posedge core_clk) disable iff (!rstn)
      txDriveEn |-> state_q == ST_SEND)
      else $error("line driven outside an answer");
   c_rd_answer: cover property (@(posedge core_clk) disable iff (!rstn)
      $fell(txDriveEn) && op_q == OP_RD);
   c_rc_answer: cover property (@(posedge core_clk) disable iff (!rstn)
      $fell(txDriveEn) && op_q == OP_RC);
   c_so_write: cover property (@(posedge core_clk) disable iff (!rstn)
      applyArg && op_q == OP_SO);
   c_mismatch: cover property (@(posedge core_clk) disable iff (!rstn)
      state_q == ST_OP1 && rxValid && !match_q);
   c_config_write: cover property (@(posedge core_clk) disable iff (!rstn)
      applyArg && op_q == OP_SS);
endmodule

// ### core/serial_io_regs.svh
// constants of the serial digital i/o command block
`ifndef SERIAL_IO_REGS_SVH
`define SERIAL_IO_REGS_SVH

`define CLK_HZ 100000000
`define BAUD_RATE 9600
`define BIT_CYCLES_DEF (`CLK_HZ / `BAUD_RATE)
`define BITS_PER_CHAR 12'h00A

`define CH_START 8'h21
`define CH_R 8'h52
`define CH_S 8'h53
`define CH_D 8'h44
`define CH_C 8'h43
`define CH_O 8'h4F
`define CH_A 8'h41

`define ADDR_RESET 8'h30
`define TDLY_RESET 8'h00
`define DIR_RESET 16'h0000
`define STARTUP_RESET 16'h0000

`define RD_LEN 3'h2
`define RC_LEN 3'h6
`define RC_ADDR_IDX 3'h4
`define RC_TDLY_IDX 3'h5

`endif

// ### core/serial_io_pkg.sv
// types of the serial digital i/o command block
package serial_io_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_OP1, ST_OP2, ST_ARG1, ST_ARG2, ST_WAIT,
      ST_SEND} parse_state_t;
   typedef enum logic [2:0] {OP_NONE, OP_RD, OP_RC, OP_SO, OP_SD, OP_SS, OP_SA,
      OP_SC} op_t;
endpackage

// ### core/serial_rx.sv
// one-character serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
module serial_rx #(
   parameter int BIT_CYCLES = 10416
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic rxLine,
   output logic [7:0] rxByte,
   output logic rxValid
);
   logic busy_q;
   logic [15:0] cnt_q;
   logic [3:0] idx_q;
   logic [7:0] shift_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         cnt_q <= 16'h0000;
         idx_q <= 4'h0;
         shift_q <= 8'h00;
         rxValid <= 1'b0;
         rxByte <= 8'h00;
      end else begin
         rxValid <= 1'b0;
         if (!busy_q) begin
            if (!rxLine) begin
               // sample at mid-bit from here on
               busy_q <= 1'b1;
               cnt_q <= 16'(BIT_CYCLES / 2);
               idx_q <= 4'h0;
            end
         end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
         end else begin
            cnt_q <= 16'(BIT_CYCLES - 1);
            idx_q <= idx_q + 4'h1;
            if (idx_q == 4'h0) begin
               // glitch, not a start bit
               if (rxLine) begin
                  busy_q <= 1'b0;
               end
            end else if (idx_q <= 4'h8) begin
               shift_q <= {rxLine, shift_q[7:1]};
            end else begin
               busy_q <= 1'b0;
               // framing error drops the character
               rxValid <= rxLine;
               rxByte <= shift_q;
            end
         end
      end
   end
endmodule

// ### testbench/host_model.sv
// host on the shared serial line: frames commands and collects answers
`timescale 1ns/1ns
module host_model #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic core_clk,
   input wire logic txdPin,
   input wire logic txDriveEn,
   output logic rxdPin
);
   logic busLevel;
   // line bias pulls the pair high while no driver is enabled
   assign busLevel = txDriveEn ? txdPin : 1'b1;
   initial rxdPin = 1'b1;
   // 8N1, lsb first, one full bit time per level
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge core_clk);
         rxdPin = frame[i];
         repeat (BIT_CYCLES - 1) @(negedge core_clk);
      end
   endtask
   // sampled at mid-bit; a bad stop bit or a missing start gives unknown
   task automatic recv_byte(output logic [7:0] b);
      int n;
      b = 8'hxx;
      n = 0;
      while (busLevel !== 1'b0 && n < 4000) begin
         @(negedge core_clk);
         n++;
      end
      if (busLevel !== 1'b0) return;
      repeat (BIT_CYCLES / 2) @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(negedge core_clk);
         b[i] = busLevel;
      end
      repeat (BIT_CYCLES) @(negedge core_clk);
      if (busLevel !== 1'b1) b = 8'hxx;
   endtask
   // a line is high when its masked bit is nonzero
   function automatic logic is_high(input logic [7:0] b, input logic [7:0] mask);
      return (b & mask) != 8'h00;
   endfunction
endmodule

// ### testbench/testbench.sv
// self-checking bench for the serial i/o command interpreter
`timescale 1ns/1ns
`include "serial_io_regs.svh"
module testbench;
   localparam int BITC = 16;
   logic coreClk, rstn, rxdPin, txdPin, txDriveEn;
   logic [15:0] lineIn, lineOut, lineOe;
   logic [7:0] ans [6];
   int n_fail, total_checks, waitCycles, seen;

   serial_io_cmd #(.BIT_CYCLES(BITC)) serial_io_cmd_inst (.core_clk(coreClk), .rstn(rstn),
      .rxdPin(rxdPin), .txdPin(txdPin), .txDriveEn(txDriveEn), .lineIn(lineIn),
      .lineOut(lineOut), .lineOe(lineOe));
   host_model #(.BIT_CYCLES(BITC)) host_model_inst (.core_clk(coreClk), .txdPin(txdPin),
      .txDriveEn(txDriveEn), .rxdPin(rxdPin));

   always #5 coreClk = ~coreClk;

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // start, address, two letters, then nArg argument bytes, high byte first
   task automatic cmd(input logic [7:0] adr, input logic [7:0] c1, input logic [7:0] c2,
      input logic [15:0] arg, input int nArg);
      host_model_inst.send_byte(`CH_START);
      host_model_inst.send_byte(adr);
      host_model_inst.send_byte(c1);
      host_model_inst.send_byte(c2);
      if (nArg == 2) host_model_inst.send_byte(arg[15:8]);
      if (nArg > 0) host_model_inst.send_byte(arg[7:0]);
      repeat (3) @(negedge coreClk);
   endtask
   task automatic get_answer(input int n);
      waitCycles = 0;
      while (txDriveEn !== 1'b1 && waitCycles < 3000) begin
         @(negedge coreClk);
         waitCycles++;
      end
      chk(16'(txDriveEn), 16'h0001);
      for (int i = 0; i < n; i++) host_model_inst.recv_byte(ans[i]);
      for (int i = 0; i < 100 && txDriveEn !== 1'b0; i++) @(negedge coreClk);
      chk(16'(txDriveEn), 16'h0000);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [15:0] exp);
      cmd(adr, `CH_R, `CH_D, 16'h0000, 0);
      get_answer(2);
      chk({ans[0], ans[1]}, exp);
   endtask

   initial begin
      coreClk = 1'b0;
      rstn = 1'b0;
      lineIn = 16'h0000;
      n_fail = 0;
      total_checks = 0;
      repeat (20) @(negedge coreClk);
      rstn = 1'b1;
      chk(lineOe, 16'h0000);
      chk({15'h0000, txDriveEn}, 16'h0000);
      // configuration straight after reset
      cmd(`ADDR_RESET, `CH_R, `CH_C, 16'h0000, 0);
      get_answer(6);
      chk({ans[0], ans[1]}, `DIR_RESET);
      chk({ans[2], ans[3]}, `STARTUP_RESET);
      chk({8'h00, ans[4]}, {8'h00, `ADDR_RESET});
      chk({8'h00, ans[5]}, {8'h00, `TDLY_RESET});
      $display("test reset_config done");
      // all lines inputs: sensed levels, high byte first
      lineIn = 16'hC852;
      rd(`ADDR_RESET, 16'hC852);
      chk(16'(waitCycles < 80), 16'h0001);
      chk(16'(host_model_inst.is_high(ans[0], 8'h80)), 16'h0001);
      chk(16'(host_model_inst.is_high(ans[1], 8'h04)), 16'h0000);
      $display("test read_inputs done");
      // directions, then writes that also touch input lines
      cmd(`ADDR_RESET, `CH_S, `CH_D, 16'h5541, 2);
      chk(lineOe, 16'h5541);
      cmd(`ADDR_RESET, `CH_S, `CH_O, 16'hFFFF, 2);
      chk(lineOut & lineOe, 16'h5541);
      chk(lineOe, 16'h5541);
      cmd(`ADDR_RESET, `CH_S, `CH_O, 16'h0001, 2);
      chk(lineOut & lineOe, 16'h0001);
      lineIn = 16'hAAAA;
      rd(`ADDR_RESET, (16'h0001 & 16'h5541) | (16'hAAAA & ~16'h5541));
      $display("test outputs done");
      // another module's address: no drive, no write
      cmd(8'h31, `CH_R, `CH_D, 16'h0000, 0);
      seen = 0;
      repeat (600) begin
         @(negedge coreClk);
         if (txDriveEn !== 1'b0) seen++;
      end
      chk(16'(seen), 16'h0000);
      cmd(8'h31, `CH_S, `CH_O, 16'hFFFF, 2);
      chk(lineOut & lineOe, 16'h0001);
      $display("test foreign_address done");
      // delay, address and startup states, then read back
      cmd(`ADDR_RESET, `CH_S, `CH_C, 16'h0002, 1);
      cmd(`ADDR_RESET, `CH_S, `CH_A, 16'h0039, 1);
      cmd(8'h39, `CH_S, `CH_S, 16'hDB40, 2);
      cmd(8'h39, `CH_R, `CH_C, 16'h0000, 0);
      get_answer(6);
      // two character times of ten bits each before the first start bit
      chk(16'(waitCycles >= 300 && waitCycles < 400), 16'h0001);
      chk({ans[0], ans[1]}, 16'h5541);
      chk({ans[2], ans[3]}, 16'hDB40 & 16'h5541);
      chk({ans[4], ans[5]}, 16'h3902);
      $display("test config_readback done");
      summarize();
   end

   // all tests take well under 50k cycles at the shortened bit time
   initial begin
      #500_000;
      n_fail++;
      $display("watchdog expired at t=%0t", $time);
      summarize();
   end
endmodule
